// file: src/ptsr_params.svh
// Constants for the pressure and temperature readout block
`ifndef PTSR_PARAMS_SVH
`define PTSR_PARAMS_SVH

// Frame layout
`define PTSR_FRAME_BYTES     3'd4
`define PTSR_FRAME_BITS      6'd32
`define PTSR_PRESS_MASK      16'h3FFF
`define PTSR_STATUS_SHIFT    6
`define PTSR_TEMP_PAD        5'h00

// Idle levels of the serial pins, used as synchroniser reset values
`define PTSR_PIN_IDLE        1'b1
`define PTSR_SCLK_IDLE       1'b0

// I2C target address, 7 bits
`define PTSR_I2C_ADDR        7'h28

// Status codes
`define PTSR_ST_NORMAL       2'h0
`define PTSR_ST_COMMAND      2'h1
`define PTSR_ST_STALE        2'h2
`define PTSR_ST_DIAG         2'h3

// Select low time that requests a measurement, in ns, and the clock period
`define PTSR_SEL_MIN_NS      8000
`define PTSR_CLK_NS          4

`endif

// file: src/ptsr_pkg.sv
// Types for the pressure and temperature readout block
package ptsr_pkg;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ADDR_ACK,
        I2C_SEND,
        I2C_GET_ACK,
        I2C_WAIT_STOP
    } ptsr_i2c_state_t;

endpackage : ptsr_pkg

// file: src/ptsr_sync.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps

module ptsr_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin in, synchronised level and edges out
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ptsr_sync_st_t;

    ptsr_sync_st_t st_q;
    ptsr_sync_st_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Next state: s1 feeds only s2
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // Register, at the pin's idle level after reset so no false edge follows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= {3{RST_VAL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise  = st_q.s2 & ~st_q.s3;
    assign fall  = ~st_q.s2 & st_q.s3;

endmodule : ptsr_sync

// file: src/ptsr_frame.sv
// Packs status, pressure and temperature into the four-byte frame
`timescale 1ns/1ps
`include "ptsr_params.svh"

module ptsr_frame (
    // Fields
    input  wire logic [1:0]  status_field,
    input  wire logic [13:0] pressure_count,
    input  wire logic [10:0] temperature_count,
    // Frame, byte one in the top bits
    output logic [31:0]      frame
);

    // Same layout serves both serial ports
    assign frame = {status_field,
                    pressure_count,
                    temperature_count,
                    `PTSR_TEMP_PAD};

endmodule : ptsr_frame

// file: src/ptsr_readout.sv
// Readout logic: I2C and SPI targets serving the measurement frame
// Function
// - One measurement is a four byte frame
// - Temperature: byte three, then byte four top
// - Pressure: byte one low six, byte two
// - Status in top two bits of byte one
// - Status codes normal, command, stale, diagnostic
// - SPI drives only data out line
// - SPI mode 0, sample on rising edge
// - SPI shifts at most four bytes
// - Selected device drives bits on clocks
// - Select low 8 us, rise starts measurement
// - I2C target answers at address 0x28
`timescale 1ns/1ps
`include "ptsr_params.svh"

module ptsr_readout #(
    parameter int        SEL_MIN_CYC = (`PTSR_SEL_MIN_NS + `PTSR_CLK_NS - 1)
                                       / `PTSR_CLK_NS,
    parameter logic[6:0] I2C_ADDR    = `PTSR_I2C_ADDR
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Measurement engine
    input  wire logic [13:0] meas_pressure,
    input  wire logic [10:0] meas_temperature,
    input  wire logic        meas_valid,
    input  wire logic        cmd_mode,
    input  wire logic        diag_fault,
    output logic             meas_start,
    // I2C pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    // SPI pins
    input  wire logic        sclk_i,
    input  wire logic        ss_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_n
);

    typedef struct packed {
        logic [13:0]               press;
        logic [10:0]               temp;
        logic                      fresh;
        ptsr_pkg::ptsr_i2c_state_t ist;
        logic [7:0]                ish;
        logic [2:0]                ibit;
        logic [1:0]                ibyte;
        logic                      sda_low;
        logic [31:0]               ifrm;
        logic [31:0]               sfrm;
        logic [5:0]                scnt;
        logic                      miso;
        logic [12:0]               selcnt;
        logic                      start;
    } ptsr_st_t;

    ptsr_st_t st_q;
    ptsr_st_t st_d;

    logic scl;
    logic scl_r;
    logic scl_f;
    logic sda;
    logic sda_r;
    logic sda_f;
    logic sclk_r;
    logic sclk_f;
    logic ss_n;
    logic ss_r;
    logic ss_f;
    logic [1:0]  status_now;
    logic [31:0] frame;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, reset to each pin's idle level
    ptsr_sync #(.RST_VAL(`PTSR_PIN_IDLE)) u_scl (
        .clk(clk), .resetn(resetn), .pin(scl_i),
        .level(scl), .rise(scl_r), .fall(scl_f));
    ptsr_sync #(.RST_VAL(`PTSR_PIN_IDLE)) u_sda (
        .clk(clk), .resetn(resetn), .pin(sda_i),
        .level(sda), .rise(sda_r), .fall(sda_f));
    ptsr_sync #(.RST_VAL(`PTSR_SCLK_IDLE)) u_sclk (
        .clk(clk), .resetn(resetn), .pin(sclk_i),
        .level(), .rise(sclk_r), .fall(sclk_f));
    ptsr_sync #(.RST_VAL(`PTSR_PIN_IDLE)) u_ss (
        .clk(clk), .resetn(resetn), .pin(ss_n_i),
        .level(ss_n), .rise(ss_r), .fall(ss_f));

    ////////////////////////////////////////////////////////////////////////
    // Status selection, priority diagnostic, command, stale, normal
    always_comb begin
        if (diag_fault) begin
            status_now = `PTSR_ST_DIAG;
        end else if (cmd_mode) begin
            status_now = `PTSR_ST_COMMAND;
        end else if (!st_q.fresh) begin
            status_now = `PTSR_ST_STALE;
        end else begin
            status_now = `PTSR_ST_NORMAL;
        end
    end

    // Frame packing shared by both ports
    ptsr_frame u_frame (
        .status_field      (status_now),
        .pressure_count    (st_q.press),
        .temperature_count (st_q.temp),
        .frame             (frame)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d       = st_q;
        st_d.start = 1'b0;

        // Result capture makes data fresh; set wins over stale clear
        if (meas_valid) begin
            st_d.press = meas_pressure;
            st_d.temp  = meas_temperature;
        end

        // SPI select low timer and measurement request on release
        if (!ss_n) begin
            if (st_q.selcnt != 13'(SEL_MIN_CYC)) begin
                st_d.selcnt = st_q.selcnt + 13'h0001;
            end
        end else begin
            st_d.selcnt = 13'h0000;
        end
        if (ss_r && st_q.selcnt == 13'(SEL_MIN_CYC)) begin
            st_d.start = 1'b1;
        end

        // SPI shifter, mode 0: bit presented at select fall, next bit
        // after each falling edge so master samples on rising edge
        if (ss_f) begin
            st_d.sfrm = {frame[30:0], 1'b0};
            st_d.miso = frame[31];
            st_d.scnt = 6'h00;
        end else if (!ss_n && sclk_r
                     && st_q.scnt != `PTSR_FRAME_BITS) begin
            st_d.scnt = st_q.scnt + 6'h01;
        end else if (!ss_n && sclk_f
                     && st_q.scnt != `PTSR_FRAME_BITS) begin
            st_d.miso = st_q.sfrm[31];
            st_d.sfrm = {st_q.sfrm[30:0], 1'b0};
        end
        if (ss_r) begin
            st_d.scnt = 6'h00;
        end
        if (ss_r && st_q.scnt == `PTSR_FRAME_BITS) begin
            st_d.fresh = 1'b0;
        end

        // I2C target
        if (sda_f && scl) begin
            st_d.ist     = ptsr_pkg::I2C_ADDR;
            st_d.ibit    = 3'h0;
            st_d.ish     = 8'h00;
            st_d.sda_low = 1'b0;
        end else if (sda_r && scl) begin
            st_d.ist     = ptsr_pkg::I2C_IDLE;
            st_d.sda_low = 1'b0;
        end else begin
            case (st_q.ist)
                ptsr_pkg::I2C_IDLE: begin
                    st_d.sda_low = 1'b0;
                end
                ptsr_pkg::I2C_ADDR: begin
                    if (scl_r) begin
                        st_d.ish  = {st_q.ish[6:0], sda};
                        st_d.ibit = st_q.ibit + 3'h1;
                        // Eighth bit in: a foreign address or a write
                        // leaves the bus alone until the next START or STOP
                        if (st_q.ibit == 3'h7
                            && {st_q.ish[6:0], sda} != {I2C_ADDR, 1'b1}) begin
                            st_d.ist = ptsr_pkg::I2C_WAIT_STOP;
                        end
                    end
                    // Byte is cleared at START, so the SCL fall that ends
                    // the START itself can never look like a match
                    if (scl_f && st_q.ibit == 3'h0
                        && st_q.ish == {I2C_ADDR, 1'b1}) begin
                        st_d.sda_low = 1'b1;
                        st_d.ifrm    = frame;
                        st_d.ibyte   = 2'h0;
                        st_d.ist     = ptsr_pkg::I2C_ADDR_ACK;
                    end
                end
                ptsr_pkg::I2C_ADDR_ACK: begin
                    if (scl_f) begin
                        st_d.sda_low = ~st_q.ifrm[31];
                        st_d.ifrm    = {st_q.ifrm[30:0], 1'b0};
                        st_d.ibit    = 3'h1;
                        st_d.ist     = ptsr_pkg::I2C_SEND;
                    end
                end
                ptsr_pkg::I2C_SEND: begin
                    if (scl_f) begin
                        if (st_q.ibit == 3'h0) begin
                            st_d.sda_low = 1'b0;
                            st_d.ist     = ptsr_pkg::I2C_GET_ACK;
                        end else begin
                            st_d.sda_low = ~st_q.ifrm[31];
                            st_d.ifrm    = {st_q.ifrm[30:0], 1'b0};
                            st_d.ibit    = st_q.ibit + 3'h1;
                        end
                    end else if (scl_r && st_q.ibit == 3'h0) begin
                        st_d.ibit = 3'h0;
                    end
                end
                ptsr_pkg::I2C_GET_ACK: begin
                    if (scl_r) begin
                        if (st_q.ibyte == 2'h3) begin
                            st_d.fresh = 1'b0;
                        end
                        if (sda || st_q.ibyte == 2'h3) begin
                            st_d.ist = ptsr_pkg::I2C_WAIT_STOP;
                        end else begin
                            st_d.ibyte = st_q.ibyte + 2'h1;
                            st_d.ist   = ptsr_pkg::I2C_ADDR_ACK;
                        end
                    end
                end
                ptsr_pkg::I2C_WAIT_STOP: begin
                    st_d.sda_low = 1'b0;
                end
                default: begin
                    st_d.ist = ptsr_pkg::I2C_IDLE;
                end
            endcase
        end

        // New result wins over any stale marking this cycle
        if (meas_valid) begin
            st_d.fresh = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{press: 14'h0000, temp: 11'h000, fresh: 1'b0,
                      ist: ptsr_pkg::I2C_IDLE, ish: 8'h00, ibit: 3'h0,
                      ibyte: 2'h0, sda_low: 1'b0, ifrm: 32'h0000_0000,
                      sfrm: 32'h0000_0000, scnt: 6'h00, miso: 1'b0,
                      selcnt: 13'h0000, start: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs: SDA open drain, MISO driven only while selected
    assign sda_o      = 1'b0;
    assign sda_oe_n   = ~st_q.sda_low;
    assign miso_o     = st_q.miso;
    assign miso_oe_n  = ss_n;
    assign meas_start = st_q.start;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_start_after_sel: assert property (
        @(posedge clk) disable iff (!resetn) meas_start |-> $past(ss_r))
        else $error("start without select rise");
    a_start_pulse: assert property (
        @(posedge clk) disable iff (!resetn) meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    a_stale_status: assert property (
        @(posedge clk) disable iff (!resetn)
        (!st_q.fresh && !diag_fault && !cmd_mode)
        |-> frame[31:30] == `PTSR_ST_STALE)
        else $error("stale not shown");
    a_press_layout: assert property (
        @(posedge clk) disable iff (!resetn) frame[29:16] == st_q.press)
        else $error("pressure misplaced");
    a_temp_layout: assert property (
        @(posedge clk) disable iff (!resetn)
        frame[15:5] == st_q.temp && frame[4:0] == `PTSR_TEMP_PAD)
        else $error("temperature misplaced");
    a_diag_status: assert property (
        @(posedge clk) disable iff (!resetn)
        diag_fault |-> frame[31:30] == `PTSR_ST_DIAG)
        else $error("diagnostic not shown");
    a_status_shift: assert property (
        @(posedge clk) disable iff (!resetn)
        (frame >> 30) == 32'(status_now))
        else $error("status misplaced");
    a_miso_hiz: assert property (
        @(posedge clk) disable iff (!resetn) ss_n |-> miso_oe_n)
        else $error("miso driven unselected");
    a_spi_count: assert property (
        @(posedge clk) disable iff (!resetn)
        st_q.scnt <= `PTSR_FRAME_BITS)
        else $error("spi count overrun");
    a_fresh_set: assert property (
        @(posedge clk) disable iff (!resetn) meas_valid |=> st_q.fresh)
        else $error("fresh not set");
    a_stale_after_read: assert property (
        @(posedge clk) disable iff (!resetn)
        (st_q.ist == ptsr_pkg::I2C_GET_ACK && scl_r && !sda_f && !sda_r
         && st_q.ibyte == 2'h3 && !meas_valid) |=> !st_q.fresh)
        else $error("full read left data fresh");

endmodule : ptsr_readout

// file: verif/ptsr_host.sv
// Host master model driving the SPI and I2C pins of the readout block
`timescale 1ns/1ps

module ptsr_host (
    // Clock
    input  wire logic clk,
    // Device outputs
    input  wire logic miso_o,
    input  wire logic miso_oe_n,
    input  wire logic sda_o,
    input  wire logic sda_oe_n,
    // Master pins
    output logic      sclk_i,
    output logic      ss_n_i,
    output logic      mosi_i,
    output logic      scl_i,
    output logic      sda_i
);
    logic sda_m;
    logic miso_line;

    // Open-drain data line with pull-up
    assign sda_i = sda_m & (sda_oe_n | sda_o);
    // Released MISO has no pull: show the inverse so a late drive shows up
    assign miso_line = miso_oe_n ? ~miso_o : miso_o;

    // Idle bus levels
    initial begin
        sclk_i = 1'b0;
        ss_n_i = 1'b1;
        mosi_i = 1'b0;
        scl_i  = 1'b1;
        sda_m  = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // Wait n falling clock edges
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    // Select, clock n bits in mode 0, release
    task automatic spi_read(input int n, output logic [31:0] d);
        d      = '0;
        ss_n_i = 1'b0;
        w(640);
        for (int i = 0; i < n; i++) begin
            mosi_i = ~mosi_i;
            w(20);
            sclk_i = 1'b1;
            d      = {d[30:0], miso_line};
            w(20);
            sclk_i = 1'b0;
        end
        w(20);
        ss_n_i = 1'b1;
        w(520);
    endtask : spi_read

    // Select pulse too short to request a measurement
    task automatic spi_pulse(input int n);
        ss_n_i = 1'b0;
        w(n);
        ss_n_i = 1'b1;
        w(520);
    endtask : spi_pulse

    // One bit slot; r is the line level in mid-high
    task automatic i2c_bit(input logic b, output logic r);
        w(4);
        sda_m = b;
        w(16);
        scl_i = 1'b1;
        w(10);
        r = sda_i;
        w(10);
        scl_i = 1'b0;
    endtask : i2c_bit

    // Addressed four-byte read, three acks then a nack
    task automatic i2c_read(input logic [6:0] a, output logic nak,
                            output logic [31:0] d);
        logic [7:0] ab;
        logic       r;
        ab    = {a, 1'b1};
        d     = '0;
        sda_m = 1'b0;
        w(20);
        scl_i = 1'b0;
        for (int i = 0; i < 8; i++) i2c_bit(ab[7-i], r);
        i2c_bit(1'b1, nak);
        for (int k = 0; k < 4 && nak === 1'b0; k++) begin
            for (int j = 0; j < 8; j++) begin
                i2c_bit(1'b1, r);
                d = {d[30:0], r};
            end
            i2c_bit(k == 3, r);
        end
        w(4);
        sda_m = 1'b0;
        w(20);
        scl_i = 1'b1;
        w(20);
        sda_m = 1'b1;
        w(520);
    endtask : i2c_read
endmodule : ptsr_host

// file: verif/ptsr_readout_tb_top.sv
// Self-checking testbench for the readout block
`timescale 1ns/1ps
`include "ptsr_params.svh"

module ptsr_readout_tb_top;
    logic        clk, resetn, meas_valid, cmd_mode, diag_fault, meas_start;
    logic [13:0] meas_pressure, p;
    logic [10:0] meas_temperature, t;
    logic        scl_i, sda_i, sda_o, sda_oe_n, nak;
    logic        sclk_i, ss_n_i, mosi_i, miso_o, miso_oe_n;
    logic [31:0] d, starts, s0;
    int          failures, compares;

    // Count limits and pressure range of a sample part for interpolation
    localparam int MIN_CNT = 1638;
    localparam int MAX_CNT = 14745;
    localparam int MIN_P   = -1000;
    localparam int MAX_P   = 1000;

    ptsr_readout #(.SEL_MIN_CYC(20)) DUT (
        .clk(clk), .resetn(resetn), .meas_pressure(meas_pressure),
        .meas_temperature(meas_temperature), .meas_valid(meas_valid),
        .cmd_mode(cmd_mode), .diag_fault(diag_fault),
        .meas_start(meas_start), .scl_i(scl_i), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .sclk_i(sclk_i),
        .ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n));

    ptsr_host host (
        .clk(clk), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .sclk_i(sclk_i), .ss_n_i(ss_n_i),
        .mosi_i(mosi_i), .scl_i(scl_i), .sda_i(sda_i));

    //////////////////////////////////////////////////////////////////////
    // Clock and request counter
    initial clk = 1'b0;
    always #2 clk = ~clk;
    initial starts = '0;
    always @(posedge clk) if (meas_start === 1'b1) starts <= starts + 1;

    // Expected frame from its fields
    function automatic logic [31:0] frame_of(logic [1:0] s, logic [13:0] pp,
                                             logic [10:0] tt);
        return {s, pp, tt, `PTSR_TEMP_PAD};
    endfunction : frame_of

    // Master-side conversions of recovered counts
    function automatic int celsius(input logic [10:0] tt);
        return int'(tt) * 200 / 2048 - 50;
    endfunction : celsius

    function automatic int press_units(input logic [13:0] pp);
        return (MAX_P - MIN_P) * (int'(pp) - MIN_CNT) / (MAX_CNT - MIN_CNT)
               + MIN_P;
    endfunction : press_units

    // Compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Unpack a frame as the master does and check every recovered field
    task automatic fields(input logic [31:0] f, input logic [1:0] s,
                          input logic [13:0] pp, input logic [10:0] tt);
        logic [7:0]  st;
        logic [13:0] gp;
        logic [10:0] gt;
        st = f[31:24] >> 6;
        gp = 14'(`PTSR_PRESS_MASK & (f[31:24] * 256 + f[23:16]));
        gt = 11'(f[15:8] * 8 + (f[7:0] >> 5));
        chk({24'h0, st}, {30'h0, s});
        chk({18'h0, gp}, {18'h0, pp});
        chk({21'h0, gt}, {21'h0, tt});
        chk(32'(celsius(gt)), 32'(celsius(tt)));
        chk(32'(press_units(gp)), 32'(press_units(pp)));
    endtask : fields

    // Verdict and end of run
    task automatic summarize;
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // Hand a finished measurement to the block
    task automatic new_meas(input logic [13:0] pp, input logic [10:0] tt);
        @(negedge clk);
        meas_pressure    = pp;
        meas_temperature = tt;
        meas_valid       = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
    endtask : new_meas

    //////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        failures = 0;
        compares = 0;
        {resetn, meas_valid, cmd_mode, diag_fault} = 4'h0;
        meas_pressure    = 14'h0000;
        meas_temperature = 11'h000;
        void'($urandom(48));
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk({31'h0, miso_oe_n}, 32'h0000_0001);
        host.spi_read(32, d);
        chk({30'h0, d[31:30]}, {30'h0, `PTSR_ST_STALE});
        chk(starts, 32'h0000_0001);
        // Corner and random fields, then stale re-read
        for (int i = 0; i < 5; i++) begin
            p = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : 14'($urandom);
            t = (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : 11'($urandom);
            new_meas(p, t);
            host.spi_read(32, d);
            chk(d, frame_of(`PTSR_ST_NORMAL, p, t));
            fields(d, `PTSR_ST_NORMAL, p, t);
            host.spi_read(32, d);
            chk(d, frame_of(`PTSR_ST_STALE, p, t));
        end
        // Early stop keeps the data fresh
        p = 14'($urandom);
        t = 11'($urandom);
        new_meas(p, t);
        host.spi_read(16, d);
        chk(d, {16'h0, `PTSR_ST_NORMAL, p});
        host.spi_read(32, d);
        chk(d, frame_of(`PTSR_ST_NORMAL, p, t));
        // Every status code in turn
        for (int c = 0; c < 4; c++) begin
            @(negedge clk);
            cmd_mode   = (c == 1);
            diag_fault = (c == 3);
            if (c != 2) new_meas(p, t);
            host.spi_read(32, d);
            chk({30'h0, d[31:30]}, c);
        end
        diag_fault = 1'b0;
        // Same frame over I2C, stale on re-read, wrong address ignored
        new_meas(p, t);
        host.i2c_read(`PTSR_I2C_ADDR, nak, d);
        chk({31'h0, nak}, 32'h0000_0000);
        chk(d, frame_of(`PTSR_ST_NORMAL, p, t));
        fields(d, `PTSR_ST_NORMAL, p, t);
        host.i2c_read(`PTSR_I2C_ADDR, nak, d);
        chk(d, frame_of(`PTSR_ST_STALE, p, t));
        host.i2c_read(7'h29, nak, d);
        chk({31'h0, nak}, 32'h0000_0001);
        // Clocks past the frame: the line holds the last bit, the pad
        host.spi_read(34, d);
        chk(d, frame_of(`PTSR_ST_STALE, p, t) << 2);
        // Short select requests nothing
        s0 = starts;
        host.spi_pulse(5);
        chk(starts, s0);
        chk({31'h0, miso_oe_n}, 32'h0000_0001);
        summarize();
    end
endmodule : ptsr_readout_tb_top
